// >>> core/sdc_defs.svh
// constants of the serial chain front end
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
`define SDC_SYNC_BYTE 8'haa
`define SDC_LEGACY_SYNC 8'h80
`define SDC_SYNC_TAIL 8'hd5
`define SDC_CMD_CLEAR 8'h83
`define SDC_CMD_FWD 8'h85
`define SDC_CMD_REV 8'h86
`define SDC_CMD_GETVAR 8'ha1
`define SDC_VAR_SPEED 7'h14
`define SDC_SPEED_MAX 12'h0c80
`define SDC_CMD_BIT 7
`define SDC_LO_BITS 5
`define SDC_HI_BITS 7
`define SDC_MAG_W 12
`define SDC_SPD_W 13
`define SDC_CNT_W 20
`define SDC_MEAS_MIN 20'h0_0008
`define SDC_MEAS_MAX 20'h3_ffff
`define SDC_CNT_ONE 20'h0_0001
`define SDC_DATA_BITS 4'h8
`define SDC_FIFO_W 8
`define SDC_FIFO_DEPTH 32
`define SDC_FRAME_BITS 4'ha
`endif

// >>> core/sdc_pkg.sv
// shared types of the serial chain front end
`include "sdc_defs.svh"
package sdc_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sdc_byte_t;
	typedef struct packed {
		logic rev;
		logic [`SDC_MAG_W-1:0] mag;
	} sdc_speed_t;
	typedef enum logic [2:0] {
		RX_HUNT, RX_SYNC_TAIL, RX_IDLE, RX_START, RX_DATA, RX_STOP
	} sdc_rx_state_t;
	typedef enum logic [3:0] {
		P_IDLE, P_DEV, P_ADDR_CMD, P_SPD_LO, P_SPD_HI, P_VAR,
		P_RESP_LO, P_RESP_HI, P_SKIP
	} sdc_parse_state_t;
endpackage

// >>> core/sdc_fifo.sv
// response byte fifo, flip-flop storage
`timescale 1ns/1ps
module sdc_fifo #(
	parameter int WIDTH = `SDC_FIFO_W,
	parameter int DEPTH = `SDC_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge clk) begin
				if (rst) begin
					mem[i] <= '0;
				end else if (push && wr_ptr == AW'(i)) begin
					mem[i] <= in_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end
endmodule

// >>> core/sdc_uart_tx.sv
// serial byte transmitter, 8N1, idles high
`timescale 1ns/1ps
module sdc_uart_tx (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// timing
	input wire logic [`SDC_CNT_W-1:0] bit_period,
	// byte in
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	// line
	output logic tx_line
);
	logic busy;
	logic [9:0] shift;
	logic [3:0] bits_left;
	logic [`SDC_CNT_W-1:0] cnt;

	assign in_ready = !busy;

	always_ff @(posedge clk) begin
		if (rst) begin
			busy <= 1'b0;
			shift <= '1;
			bits_left <= '0;
			cnt <= '0;
			tx_line <= 1'b1;
		end else if (!busy) begin
			tx_line <= 1'b1;
			if (in_valid) begin
				busy <= 1'b1;
				shift <= {1'b1, in_data, 1'b0};
				bits_left <= `SDC_FRAME_BITS;
				cnt <= '0;
			end
		end else if (cnt == '0) begin
			if (bits_left == '0) begin
				busy <= 1'b0;
				tx_line <= 1'b1;
			end else begin
				tx_line <= shift[0];
				shift <= {1'b1, shift[9:1]};
				bits_left <= bits_left - 1'b1;
				cnt <= bit_period - `SDC_CNT_ONE;
			end
		end else begin
			cnt <= cnt - `SDC_CNT_ONE;
		end
	end
endmodule

// >>> core/sdc_frontend.sv
// serial chain front end: receive, address, decode, answer on request
`timescale 1ns/1ps

// Overview of operation
// - unique device number; addressed packets are used only with our number, compact packets always
// - bytes are sent back only when a received command asks for them
// - transmit line rests high whenever no byte is being sent
// - transmit pin is own transmitter ANDed with the chain merge input
// - with autobaud on, bit time is measured from the first 0xAA
// - after baud lock, packets that start with 0x80 are discarded
// - motor stays disabled after restart or error until 0x83 arrives
// - 0x85 forward, 0x86 reverse, then low five bits, then upper bits
// - speed target is signed, -3200 to 3200, 3200 meaning full speed
module sdc_frontend (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial pins
	input wire logic rx_pin,
	input wire logic chain_merge_input,
	output logic tx_pin,
	// configuration
	input wire logic autobaud_en,
	input wire logic [`SDC_CNT_W-1:0] fixed_bit_period,
	input wire logic [6:0] device_number,
	// motor side
	input wire logic fault,
	output logic motor_enable,
	output logic signed [`SDC_SPD_W-1:0] speed_target,
	output logic speed_update,
	output logic baud_locked,
	output logic frame_error
);
	// pin synchronisers
	logic rx_s1;
	logic rx_s2;
	logic rx_prev;
	logic merge_s1;
	logic merge_s2;

	// receiver
	sdc_pkg::sdc_rx_state_t rx_state;
	logic [`SDC_CNT_W-1:0] cnt;
	logic [`SDC_CNT_W-1:0] tail;
	logic [`SDC_CNT_W-1:0] bit_period;
	logic [3:0] bitn;
	logic [7:0] shreg;
	sdc_pkg::sdc_byte_t rx_byte;
	logic fall;

	// parser
	sdc_pkg::sdc_parse_state_t pstate;
	sdc_pkg::sdc_parse_state_t exec_state;
	sdc_pkg::sdc_speed_t spd;
	logic [7:0] cmd_byte;
	logic exec_clear;
	logic clear_cmd;
	logic [`SDC_LO_BITS-1:0] spd_lo;
	logic [`SDC_MAG_W-1:0] raw_mag;
	logic [`SDC_MAG_W-1:0] next_mag;
	logic [7:0] resp_lo;
	logic [7:0] resp_hi;

	// response path
	logic fifo_in_valid;
	logic [7:0] fifo_in_data;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic tx_ready;
	logic tx_line;

	// the host's line reaches every slave and is treated as asynchronous
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
			rx_prev <= rx_s2;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			merge_s1 <= 1'b1;
			merge_s2 <= 1'b1;
		end else begin
			merge_s1 <= chain_merge_input;
			merge_s2 <= merge_s1;
		end
	end

	assign fall = rx_prev && !rx_s2;

	// receiver state, bit timing and byte assembly
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_state <= sdc_pkg::RX_HUNT;
			cnt <= '0;
			tail <= '0;
			bit_period <= fixed_bit_period;
			bitn <= '0;
			shreg <= '0;
			rx_byte <= '0;
			baud_locked <= 1'b0;
			frame_error <= 1'b0;
		end else begin
			rx_byte.valid <= 1'b0;
			frame_error <= 1'b0;
			case (rx_state)
				sdc_pkg::RX_HUNT: begin
					// bits 0 of 0xaa is zero: start plus b0 is one low
					// run of two bit times
					if (!autobaud_en) begin
						bit_period <= fixed_bit_period;
						baud_locked <= 1'b1;
						rx_state <= sdc_pkg::RX_IDLE;
					end else if (!rx_s2) begin
						if (cnt != `SDC_MEAS_MAX) begin
							cnt <= cnt + `SDC_CNT_ONE;
						end
					end else if (cnt != '0) begin
						cnt <= '0;
						if (cnt >= `SDC_MEAS_MIN && cnt != `SDC_MEAS_MAX) begin
							bit_period <= cnt >> 1;
							// first check point is the middle of b1
							tail <= (cnt >> 2) - `SDC_CNT_ONE;
							bitn <= '0;
							rx_state <= sdc_pkg::RX_SYNC_TAIL;
						end
					end
				end
				sdc_pkg::RX_SYNC_TAIL: begin
					// b1..b7 and stop are all checked, so another byte's
					// short start bit cannot fake a lock
					if (cnt == tail) begin
						cnt <= '0;
						tail <= bit_period - `SDC_CNT_ONE;
						shreg <= {rx_s2, shreg[7:1]};
						bitn <= bitn + 1'b1;
						if (bitn == `SDC_DATA_BITS - 1'b1) begin
							if ({rx_s2, shreg[7:1]} == `SDC_SYNC_TAIL) begin
								baud_locked <= 1'b1;
								rx_byte <= {1'b1, `SDC_SYNC_BYTE};
								rx_state <= sdc_pkg::RX_IDLE;
							end else begin
								rx_state <= sdc_pkg::RX_HUNT;
							end
						end
					end else begin
						cnt <= cnt + `SDC_CNT_ONE;
					end
				end
				sdc_pkg::RX_IDLE: begin
					cnt <= '0;
					if (fall) begin
						rx_state <= sdc_pkg::RX_START;
					end
				end
				sdc_pkg::RX_START: begin
					if (cnt == (bit_period >> 1)) begin
						cnt <= '0;
						bitn <= '0;
						rx_state <= rx_s2 ? sdc_pkg::RX_IDLE
							: sdc_pkg::RX_DATA;
					end else begin
						cnt <= cnt + `SDC_CNT_ONE;
					end
				end
				sdc_pkg::RX_DATA: begin
					if (cnt == bit_period - `SDC_CNT_ONE) begin
						cnt <= '0;
						shreg <= {rx_s2, shreg[7:1]};
						bitn <= bitn + 1'b1;
						if (bitn == `SDC_DATA_BITS - 1'b1) begin
							rx_state <= sdc_pkg::RX_STOP;
						end
					end else begin
						cnt <= cnt + `SDC_CNT_ONE;
					end
				end
				sdc_pkg::RX_STOP: begin
					if (cnt == bit_period - `SDC_CNT_ONE) begin
						cnt <= '0;
						rx_state <= sdc_pkg::RX_IDLE;
						if (rx_s2) begin
							rx_byte <= {1'b1, shreg};
						end else begin
							frame_error <= 1'b1;
						end
					end else begin
						cnt <= cnt + `SDC_CNT_ONE;
					end
				end
				default: begin
					rx_state <= sdc_pkg::RX_HUNT;
				end
			endcase
		end
	end

	// command byte, whether compact or carried in an addressed packet
	assign cmd_byte = {1'b1, rx_byte.data[6:0]};

	always_comb begin
		exec_state = sdc_pkg::P_IDLE;
		exec_clear = 1'b0;
		case (cmd_byte)
			`SDC_CMD_CLEAR: exec_clear = 1'b1;
			`SDC_CMD_FWD: exec_state = sdc_pkg::P_SPD_LO;
			`SDC_CMD_REV: exec_state = sdc_pkg::P_SPD_LO;
			`SDC_CMD_GETVAR: exec_state = sdc_pkg::P_VAR;
			default: exec_state = sdc_pkg::P_IDLE;
		endcase
	end

	// magnitude is the low five bits followed by the upper bits
	assign raw_mag = {rx_byte.data[`SDC_HI_BITS-1:0], spd_lo};
	assign next_mag = (raw_mag > `SDC_SPEED_MAX) ? `SDC_SPEED_MAX
		: raw_mag;

	// packet parser; outside P_RESP_LO and P_RESP_HI a byte with its top bit set starts a packet
	always_ff @(posedge clk) begin
		if (rst) begin
			pstate <= sdc_pkg::P_IDLE;
			spd <= '0;
			spd_lo <= '0;
			clear_cmd <= 1'b0;
			speed_update <= 1'b0;
			resp_lo <= '0;
			resp_hi <= '0;
		end else begin
			clear_cmd <= 1'b0;
			speed_update <= 1'b0;
			if (pstate == sdc_pkg::P_RESP_LO) begin
				if (fifo_in_ready) begin
					pstate <= sdc_pkg::P_RESP_HI;
				end
			end else if (pstate == sdc_pkg::P_RESP_HI) begin
				if (fifo_in_ready) begin
					pstate <= sdc_pkg::P_IDLE;
				end
			end else if (rx_byte.valid) begin
				if (rx_byte.data[`SDC_CMD_BIT]) begin
					if (rx_byte.data == `SDC_SYNC_BYTE) begin
						pstate <= sdc_pkg::P_DEV;
					end else if (rx_byte.data == `SDC_LEGACY_SYNC) begin
						pstate <= sdc_pkg::P_SKIP;
					end else begin
						pstate <= exec_state;
						clear_cmd <= exec_clear;
						spd.rev <= (cmd_byte == `SDC_CMD_REV);
					end
				end else begin
					case (pstate)
						sdc_pkg::P_DEV: begin
							pstate <= (rx_byte.data[6:0] == device_number)
								? sdc_pkg::P_ADDR_CMD
								: sdc_pkg::P_SKIP;
						end
						sdc_pkg::P_ADDR_CMD: begin
							pstate <= exec_state;
							clear_cmd <= exec_clear;
							spd.rev <= (cmd_byte == `SDC_CMD_REV);
						end
						sdc_pkg::P_SPD_LO: begin
							spd_lo <= rx_byte.data[`SDC_LO_BITS-1:0];
							pstate <= sdc_pkg::P_SPD_HI;
						end
						sdc_pkg::P_SPD_HI: begin
							spd.mag <= next_mag;
							speed_update <= 1'b1;
							pstate <= sdc_pkg::P_IDLE;
						end
						sdc_pkg::P_VAR: begin
							// only a request produces bytes on the return path
							if (rx_byte.data[6:0] == `SDC_VAR_SPEED) begin
								resp_lo <= speed_target[7:0];
								resp_hi <= {{3{speed_target[`SDC_SPD_W-1]}},
									speed_target[`SDC_SPD_W-1:8]};
							end else begin
								resp_lo <= {6'h00, baud_locked, motor_enable};
								resp_hi <= 8'h00;
							end
							pstate <= sdc_pkg::P_RESP_LO;
						end
						default: begin
							pstate <= pstate;
						end
					endcase
				end
			end
		end
	end

	// signed target follows the direction chosen by the command byte
	always_ff @(posedge clk) begin
		if (rst) begin
			speed_target <= '0;
		end else if (speed_update) begin
			speed_target <= spd.rev ? -$signed({1'b0, spd.mag})
				: $signed({1'b0, spd.mag});
		end
	end

	// errors outrank a clear arriving in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			motor_enable <= 1'b0;
		end else if (fault || frame_error) begin
			motor_enable <= 1'b0;
		end else if (clear_cmd) begin
			motor_enable <= 1'b1;
		end
	end

	assign fifo_in_valid = (pstate == sdc_pkg::P_RESP_LO)
		|| (pstate == sdc_pkg::P_RESP_HI);
	assign fifo_in_data = (pstate == sdc_pkg::P_RESP_HI) ? resp_hi
		: resp_lo;

	sdc_fifo #(
		.WIDTH(`SDC_FIFO_W),
		.DEPTH(`SDC_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(fifo_in_valid),
		.in_data(fifo_in_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(tx_ready)
	);

	sdc_uart_tx u_tx (
		.clk(clk),
		.rst(rst),
		.bit_period(bit_period),
		.in_valid(fifo_out_valid),
		.in_data(fifo_out_data),
		.in_ready(tx_ready),
		.tx_line(tx_line)
	);

	// merging here saves an external gate in the chain
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_pin <= 1'b1;
		end else begin
			tx_pin <= tx_line & merge_s2;
		end
	end
endmodule

// >>> test/sdc_frontend_properties.sv
// port properties of the serial chain front end
`timescale 1ns/1ps
`include "sdc_defs.svh"
module sdc_frontend_properties (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial pins
	input wire logic rx_pin,
	input wire logic chain_merge_input,
	input wire logic tx_pin,
	// configuration
	input wire logic autobaud_en,
	input wire logic [`SDC_CNT_W-1:0] fixed_bit_period,
	input wire logic [6:0] device_number,
	// motor side
	input wire logic fault,
	input wire logic motor_enable,
	input wire logic signed [`SDC_SPD_W-1:0] speed_target,
	input wire logic speed_update,
	input wire logic baud_locked,
	input wire logic frame_error
);
	localparam int SPD_MAX = 3200;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_merge_low;
		!chain_merge_input [*2];
	endsequence
	sequence s_error;
		fault || frame_error;
	endsequence
	AST_RESET_STATE: assert property (disable iff (1'b0) rst |=>
		tx_pin && !motor_enable && speed_target == 0 && !baud_locked)
		else $error("outputs not at reset values");
	AST_MERGE_PASS: assert property (s_merge_low |-> ##2 !tx_pin)
		else $error("merge low did not reach tx");
	AST_ERROR_OFF: assert property (s_error |-> ##[1:2] !motor_enable)
		else $error("motor still enabled after error");
	AST_ENABLE_CAUSE: assert property ($rose(motor_enable) |-> !$past(fault))
		else $error("motor enabled right after fault");
	AST_UPD_PULSE: assert property (speed_update |=> !speed_update)
		else $error("speed update longer than one cycle");
	AST_HOLD: assert property (!speed_update |=> $stable(speed_target))
		else $error("speed target moved without update");
	AST_RANGE: assert property (speed_target >= -SPD_MAX &&
		speed_target <= SPD_MAX)
		else $error("speed target out of range");
	AST_LOCK_KEPT: assert property (baud_locked |=> baud_locked)
		else $error("baud lock lost");
endmodule

bind sdc_frontend sdc_frontend_properties u_props (.clk, .rst, .rx_pin,
	.chain_merge_input, .tx_pin, .autobaud_en, .fixed_bit_period,
	.device_number, .fault, .motor_enable, .speed_target, .speed_update,
	.baud_locked, .frame_error);

// >>> test/sdc_host_model.sv
// host on the shared serial line: sends bytes, reads replies
`timescale 1ns/1ps
module sdc_host_model #(
	parameter int BIT = 16,
	parameter int START_WAIT = 100000
) (
	// clock
	input wire logic clk,
	// serial lines
	output logic rx_line,
	input wire logic tx_line
);
	// line idles high, as a pulled-up serial wire does
	initial rx_line = 1'b1;
	task automatic power_wait;
		repeat (START_WAIT) @(posedge clk);
	endtask
	// 8N1, lsb first; a low stop bit only to force a framing fault
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		@(posedge clk) #1;
		for (int i = 0; i < 10; i++) begin
			rx_line = f[i];
			repeat (BIT) @(posedge clk);
			#1;
		end
		rx_line = 1'b1;
		repeat (2 * BIT) @(posedge clk);
		#1;
	endtask
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		b = 8'h00;
		for (n = 0; n < 3000 && tx_line !== 1'b0; n++)
			@(posedge clk);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			b[i] = tx_line;
		end
		repeat (BIT) @(posedge clk);
		ok = (n < 3000) && (tx_line === 1'b1);
	endtask
endmodule

// >>> test/test_serial_daisy_chain_frontend.sv
// self-checking bench of the serial chain front end
`timescale 1ns/1ps
`include "sdc_defs.svh"
module test_serial_daisy_chain_frontend;
	localparam int BIT = 16;
	localparam logic [6:0] DEV = 7'h0d;
	logic clk, rst, rx_pin, chain_merge_input, tx_pin, fault;
	logic motor_enable, speed_update, baud_locked, frame_error;
	logic signed [`SDC_SPD_W-1:0] speed_target;
	int fails = 0, n_compared = 0, n_upd = 0, n_ferr = 0, cycles = 0;
	sdc_frontend u_dut (.clk, .rst, .rx_pin, .chain_merge_input,
		.tx_pin, .autobaud_en(1'b1), .fixed_bit_period(20'h0_0010),
		.device_number(DEV), .fault, .motor_enable, .speed_target,
		.speed_update, .baud_locked, .frame_error);
	sdc_host_model #(.BIT(BIT), .START_WAIT(200)) u_host (.clk,
		.rx_line(rx_pin), .tx_line(tx_pin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// about 8.5k cycles of traffic are expected
	always @(posedge clk) begin
		cycles++;
		n_upd += (speed_update === 1'b1);
		n_ferr += (frame_error === 1'b1);
		if (cycles == 60000) begin
			fails++;
			test_done;
		end
	end
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic spd(input logic adr, input logic [6:0] dev,
		input logic [7:0] cmd, input logic [11:0] mag);
		if (adr) begin
			u_host.send(8'haa, 1'b1);
			u_host.send({1'b0, dev}, 1'b1);
		end
		u_host.send(adr ? {1'b0, cmd[6:0]} : cmd, 1'b1);
		u_host.send({3'h0, mag[4:0]}, 1'b1);
		u_host.send({1'b0, mag[11:5]}, 1'b1);
	endtask
	task automatic t_reset_state;
		u_host.power_wait;
		chk("tx_idle", {15'h0, tx_pin}, 16'h0001);
		chk("motor", {15'h0, motor_enable}, 16'h0000);
		chk("target", 16'(speed_target), 16'h0000);
		u_host.send(8'h83, 1'b1);
		chk("prelock_motor", {15'h0, motor_enable}, 16'h0000);
		chk("prelock", {15'h0, baud_locked}, 16'h0000);
		// idle lets a false sync measurement run out before 0xaa
		repeat (20 * BIT) @(posedge clk);
		u_host.send(8'h80, 1'b1);
		repeat (40 * BIT) @(posedge clk);
		#1;
	endtask
	task automatic t_lock;
		spd(1'b1, DEV, 8'h85, 12'hc80);
		chk("locked", {15'h0, baud_locked}, 16'h0001);
		chk("fwd_full", 16'(speed_target), 16'h0c80);
	endtask
	task automatic t_enable;
		u_host.send(8'h83, 1'b1);
		chk("enabled", {15'h0, motor_enable}, 16'h0001);
		fault = 1'b1;
		@(posedge clk) #1;
		fault = 1'b0;
		@(posedge clk) #1;
		chk("fault_off", {15'h0, motor_enable}, 16'h0000);
		u_host.send(8'h83, 1'b1);
	endtask
	task automatic t_address;
		int n0;
		n0 = n_upd;
		spd(1'b1, DEV ^ 7'h01, 8'h86, 12'h064);
		chk("other_dev", 16'(n_upd - n0), 16'h0000);
		spd(1'b0, DEV, 8'h86, 12'h064);
		chk("rev", 16'(speed_target), 16'hff9c);
		spd(1'b1, DEV, 8'h85, 12'hfff);
		chk("clamp", 16'(speed_target), 16'h0c80);
		spd(1'b0, DEV, 8'h86, 12'hc80);
		chk("rev_full", 16'(speed_target), 16'hf380);
		n0 = n_upd;
		u_host.send(8'h80, 1'b1);
		u_host.send({1'b0, DEV}, 1'b1);
		u_host.send(8'h05, 1'b1);
		u_host.send(8'h10, 1'b1);
		u_host.send(8'h00, 1'b1);
		chk("legacy", 16'(n_upd - n0), 16'h0000);
	endtask
	task automatic t_reply;
		logic [7:0] lo, hi;
		logic ok;
		fork
			u_host.recv(lo, ok);
			begin
				u_host.send(8'ha1, 1'b1);
				u_host.send(8'h14, 1'b1);
			end
		join
		u_host.recv(hi, ok);
		chk("reply_lo", {8'h00, lo}, 16'h0080);
		chk("reply_hi", {7'h00, ok, hi}, 16'h01f3);
	endtask
	task automatic t_merge;
		chain_merge_input = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("merge_low", {15'h0, tx_pin}, 16'h0000);
		chain_merge_input = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("merge_high", {15'h0, tx_pin}, 16'h0001);
	endtask
	task automatic t_frame;
		int n0;
		n0 = n_ferr;
		u_host.send(8'h83, 1'b0);
		chk("frame_err", 16'(n_ferr - n0), 16'h0001);
		chk("frame_off", {15'h0, motor_enable}, 16'h0000);
	endtask
	// status reply goes through the response fifo inside the top
	task automatic t_status;
		logic [7:0] lo, hi;
		logic ok;
		fork
			u_host.recv(lo, ok);
			begin
				u_host.send(8'ha1, 1'b1);
				u_host.send(8'h00, 1'b1);
			end
		join
		chk("status_lo", {7'h00, ok, lo}, 16'h0102);
		u_host.recv(hi, ok);
		chk("status_hi", {7'h00, ok, hi}, 16'h0100);
		chk("status_motor", {15'h0, motor_enable}, 16'h0000);
	endtask
	initial begin
		rst = 1'b1;
		chain_merge_input = 1'b1;
		fault = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset_state;
		t_lock;
		t_enable;
		t_address;
		t_reply;
		t_merge;
		t_frame;
		t_status;
		test_done;
	end
endmodule
